// File: design/link_led_pkg.sv
// Purpose: Constants for the link indicator and general control registers
// Assumes: 100 MHz pclk, APB with 32-bit data, one word per register
// Notes:   Printed offsets are register indices; byte address is index times four
package link_led_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_LED_CTRL  = 8'h18;
  localparam logic [7:0]  IDX_PHY_CTRL  = 8'h19;
  localparam logic [11:0] ADDR_LED_CTRL = {2'b00, IDX_LED_CTRL, 2'b00};
  localparam logic [11:0] ADDR_PHY_CTRL = {2'b00, IDX_PHY_CTRL, 2'b00};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BLINK_LO  = 9;
  localparam int BLINK_HI  = 10;
  localparam int LED_POL   = 7;
  localparam int LED_FORCE = 4;
  localparam int LED_ONOFF = 1;
  localparam int AMDIX_EN  = 15;
  localparam int FMDIX     = 14;
  localparam int PAUSE_RX  = 13;
  localparam int PAUSE_TX  = 12;
  localparam int NEG_LINK  = 11;
  localparam int STR_BYP   = 7;
  localparam int IND_MODE  = 5;
  localparam int ADDR_HI   = 4;
  localparam int ADV_PAUSE = 10;
  localparam int ADV_ASM   = 11;

  // Writable bits; everything else reads zero or live status
  localparam logic [15:0] LED_WMASK = 16'h0692;
  localparam logic [15:0] PHY_WMASK = 16'hc0a0;
  localparam logic [15:0] LED_RST   = 16'h0400;
  localparam logic [15:0] PHY_RST   = 16'h8000;

  // ----------------------------------------------------------------
  // Blink timing
  // ----------------------------------------------------------------
  localparam logic [1:0] RATE_20HZ = 2'h0;
  localparam logic [1:0] RATE_10HZ = 2'h1;
  localparam logic [1:0] RATE_5HZ  = 2'h2;
  localparam logic [1:0] RATE_2HZ  = 2'h3;
  localparam int HALF_20HZ_MS = 50;
  localparam int HALF_10HZ_MS = 100;
  localparam int HALF_5HZ_MS  = 200;
  localparam int HALF_2HZ_MS  = 500;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int STRAP_SYNC    = 2;

  typedef enum logic [0:0] {
    PHASE_OFF = 1'b0,
    PHASE_ON  = 1'b1
  } blink_phase_t;

endpackage

// File: design/link_led_ctrl.sv
// Purpose: Link indicator control and general control/status registers on APB
// Assumes: Link and negotiation inputs come from logic on pclk; straps are pins
// Notes:   Zero-wait APB slave, read data is registered in the setup cycle
//
// Added by the designer: the APB register port.
module link_led_ctrl
  import link_led_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        strap_led_pol,
  input  wire logic        strap_auto_xover,
  input  wire logic        strap_ind_mode,
  input  wire logic [4:0]  strap_station_addr,
  input  wire logic        link_up,
  input  wire logic        link_speed100,
  input  wire logic        link_full_duplex,
  input  wire logic        link_by_autoneg,
  input  wire logic        activity,
  input  wire logic [15:0] local_ability_advert,
  input  wire logic [15:0] partner_ability_advert,
  output logic             link_indicator_out,
  output logic             auto_crossover_en,
  output logic             tx_on_rx_wire_pair
);

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  logic [7:0] strap_s1;
  logic [7:0] strap_s2;
  logic [1:0] strap_wait;
  logic       strap_load;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1 <= 8'h00;
      strap_s2 <= 8'h00;
    end else begin
      strap_s1 <= {strap_station_addr, strap_ind_mode, strap_auto_xover, strap_led_pol};
      strap_s2 <= strap_s1;
    end
  end

  // Straps are sampled once, after the synchroniser has filled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_wait <= 2'h0;
    end else if (strap_wait != 2'(STRAP_SYNC + 1)) begin
      strap_wait <= strap_wait + 2'h1;
    end
  end

  assign strap_load = (strap_wait == 2'(STRAP_SYNC));

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  logic        setup_ph;
  logic        wr_ok;
  logic        hit_led;
  logic        hit_phy;
  logic [15:0] led_ctrl;
  logic [15:0] phy_ctrl;
  logic [4:0]  station_addr;
  logic        pause_rx;
  logic        pause_tx;
  logic        neg_link;

  assign setup_ph = psel && !penable;
  assign hit_led  = (paddr == ADDR_LED_CTRL);
  assign hit_phy  = (paddr == ADDR_PHY_CTRL);
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !hit_led && !hit_phy;
  assign wr_ok    = psel && penable && pwrite;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wmask);
    logic [15:0] lanes;
    lanes = {{8{pstrb[1]}}, {8{pstrb[0]}}} & wmask;
    return (old & ~lanes) | (pwdata[15:0] & lanes);
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_ctrl <= LED_RST;
    end else if (wr_ok && hit_led) begin
      led_ctrl <= merge(led_ctrl, LED_WMASK);
    end else if (strap_load) begin
      led_ctrl[LED_POL] <= ~strap_s2[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_ctrl <= PHY_RST;
    end else if (wr_ok && hit_phy) begin
      phy_ctrl <= merge(phy_ctrl, PHY_WMASK);
    end else if (strap_load) begin
      phy_ctrl[AMDIX_EN] <= strap_s2[1];
      phy_ctrl[IND_MODE] <= strap_s2[2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      station_addr <= 5'h00;
    end else if (strap_load) begin
      station_addr <= strap_s2[7:3];
    end
  end

  // Read data is built from the stored control bits plus live status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (hit_led) begin
        prdata[15:0] <= led_ctrl & LED_WMASK;
      end else if (hit_phy) begin
        prdata[15:0] <= (phy_ctrl & PHY_WMASK)
                      | {2'b00, pause_rx, pause_tx, neg_link, 6'h00, station_addr};
      end
    end
  end

  // ----------------------------------------------------------------
  // Negotiation status
  // ----------------------------------------------------------------
  logic fd_link;
  logic lp;
  logic la;
  logic rp;
  logic ra;

  assign fd_link = link_up && link_by_autoneg && link_full_duplex;
  assign lp = local_ability_advert[ADV_PAUSE];
  assign la = local_ability_advert[ADV_ASM];
  assign rp = partner_ability_advert[ADV_PAUSE];
  assign ra = partner_ability_advert[ADV_ASM];

  // Symmetric pause enables both ways; asymmetric pairs enable one way only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_rx <= 1'b0;
      pause_tx <= 1'b0;
      neg_link <= 1'b0;
    end else begin
      pause_rx <= fd_link && ((lp && rp) || (lp && la && !rp && ra));
      pause_tx <= fd_link && ((lp && rp) || (!lp && la && rp && ra));
      neg_link <= fd_link && link_speed100;
    end
  end

  // ----------------------------------------------------------------
  // Crossover control
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_crossover_en  <= 1'b0;
      tx_on_rx_wire_pair <= 1'b0;
    end else begin
      auto_crossover_en  <= phy_ctrl[AMDIX_EN];
      tx_on_rx_wire_pair <= phy_ctrl[FMDIX];
    end
  end

  // ----------------------------------------------------------------
  // Blink timing
  // ----------------------------------------------------------------
  logic [16:0]  tick_cnt;
  logic         tick;
  logic [9:0]   half_ms;
  logic [9:0]   ms_cnt;
  logic         half_done;
  logic [9:0]   stretch_cnt;
  logic         act_held;
  blink_phase_t phase;

  function automatic logic [9:0] half_period(input logic [1:0] code);
    case (code)
      RATE_20HZ: return 10'(HALF_20HZ_MS);
      RATE_10HZ: return 10'(HALF_10HZ_MS);
      RATE_5HZ:  return 10'(HALF_5HZ_MS);
      default:   return 10'(HALF_2HZ_MS);
    endcase
  endfunction

  assign half_ms = half_period(led_ctrl[BLINK_HI:BLINK_LO]);

  // One pulse per millisecond
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 17'h00000;
    end else if (tick_cnt == 17'(TICK_CYCLES - 1)) begin
      tick_cnt <= 17'h00000;
    end else begin
      tick_cnt <= tick_cnt + 17'h00001;
    end
  end

  assign tick      = (tick_cnt == 17'(TICK_CYCLES - 1));
  assign half_done = tick && (ms_cnt >= half_ms - 10'h001);

  // Half-period count restarts while idle so a blink begins with a full on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt <= 10'h000;
    end else if (!act_held || half_done) begin
      ms_cnt <= 10'h000;
    end else if (tick) begin
      ms_cnt <= ms_cnt + 10'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= PHASE_ON;
    end else if (!act_held) begin
      phase <= PHASE_ON;
    end else if (half_done) begin
      case (phase)
        PHASE_ON:  phase <= PHASE_OFF;
        PHASE_OFF: phase <= PHASE_ON;
        default:   phase <= PHASE_ON;
      endcase
    end
  end

  // Stretching keeps short bursts visible for at least one half-period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stretch_cnt <= 10'h000;
    end else if (activity) begin
      stretch_cnt <= half_ms;
    end else if (tick && stretch_cnt != 10'h000) begin
      stretch_cnt <= stretch_cnt - 10'h001;
    end
  end

  assign act_held = activity || (stretch_cnt != 10'h000);

  // ----------------------------------------------------------------
  // Indicator output
  // ----------------------------------------------------------------
  logic ind_on;

  always_comb begin
    if (led_ctrl[LED_FORCE]) begin
      ind_on = led_ctrl[LED_ONOFF];
    end else if (phy_ctrl[IND_MODE]) begin
      ind_on = link_up;
    end else if (phy_ctrl[STR_BYP]) begin
      ind_on = link_up && !activity;
    end else begin
      ind_on = link_up && (!act_held || phase == PHASE_ON);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_indicator_out <= 1'b0;
    end else begin
      link_indicator_out <= led_ctrl[LED_POL] ? ind_on : !ind_on;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_reserved_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && (hit_led || hit_phy)
      |-> prdata[31:16] == 16'h0000 && (hit_led ? prdata[15:11] == 5'h00
                                                : prdata[10:8] == 3'h0))
    else $error("reserved bits read nonzero");

  a_blink_rate: assert property (
    @(posedge pclk) disable iff (!presetn)
    led_ctrl[BLINK_HI:BLINK_LO] == RATE_5HZ |-> half_ms == 10'h0c8)
    else $error("wrong half period for default rate");

  a_polarity_out: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 $stable(led_ctrl) && $stable(link_up) && led_ctrl[LED_FORCE]
      |-> link_indicator_out == (led_ctrl[LED_POL] ~^ led_ctrl[LED_ONOFF]))
    else $error("indicator polarity wrong");

  a_strap_pol: assert property (
    @(posedge pclk) disable iff (!presetn)
    strap_load && !(wr_ok && hit_led) |=> led_ctrl[LED_POL] == !$past(strap_s2[0]))
    else $error("polarity strap not taken inverted");

  a_force_led: assert property (
    @(posedge pclk) disable iff (!presetn)
    led_ctrl[LED_FORCE] && led_ctrl[LED_POL] |=> link_indicator_out == $past(led_ctrl[LED_ONOFF]))
    else $error("forced indicator level not driven");

  a_crossover: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ok && hit_phy && pstrb[1] |=> ##1 tx_on_rx_wire_pair == $past(pwdata[FMDIX], 2))
    else $error("forced crossover not applied");

  a_pause_fd: assert property (
    @(posedge pclk) disable iff (!presetn)
    !fd_link |=> !pause_rx && !pause_tx)
    else $error("pause resolved without full duplex");

  a_pause_sym: assert property (
    @(posedge pclk) disable iff (!presetn)
    fd_link && lp && rp |=> pause_tx && pause_rx)
    else $error("symmetric pause not resolved");

  a_neg_link: assert property (
    @(posedge pclk) disable iff (!presetn)
    neg_link |-> $past(link_up && link_speed100 && link_full_duplex && link_by_autoneg))
    else $error("negotiated link set without cause");

  a_bypass_raw: assert property (
    @(posedge pclk) disable iff (!presetn)
    !led_ctrl[LED_FORCE] && !phy_ctrl[IND_MODE] && phy_ctrl[STR_BYP] && led_ctrl[LED_POL]
      |=> link_indicator_out == $past(link_up && !activity))
    else $error("bypass does not show raw state");

  a_phase_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    act_held && !half_done && $stable(act_held) |=> $stable(phase))
    else $error("blink phase changed early");

endmodule

// File: verif/led_watch.sv
// Purpose: Far-side model of the LED, measuring how long each level is held
// Assumes: Indicator output sampled on pclk
// Notes:   run_len holds the length of the last finished level, in cycles
module led_watch (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        led,
  output logic      [15:0] run_len,
  output logic      [7:0]  toggles
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        prev;
  logic [15:0] cnt;

  // ----------------------------------------------------------------
  // Level timing
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev    <= 1'b0;
      cnt     <= 16'h0001;
      run_len <= 16'h0000;
      toggles <= 8'h00;
    end else if (led != prev) begin
      prev    <= led;
      run_len <= cnt;
      cnt     <= 16'h0001;
      toggles <= toggles + 8'h01;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule

// File: verif/tb.sv
// Purpose: Self-checking bench for the indicator and general control registers
// Assumes: APB master on pclk, tick shortened to 10 cycles
// Notes:   Straps fixed: polarity pin high, crossover strap high, address 0x0b
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import link_led_pkg::*;
  localparam int TK = 10;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, er;
  logic        link_up = 1'b0, spd = 1'b0, fdx = 1'b0, aneg = 1'b0, act = 1'b0;
  logic [15:0] la = 16'h0, pa = 16'h0, run_len;
  logic [7:0]  toggles;
  logic        led, xen, xov;
  int          failures = 0, check_count = 0, wt = 0;
  // Pause outcome for each advert combination, index {ra, rp, la, lp}
  localparam logic [15:0] RX_TAB = 16'ha8a0;
  localparam logic [15:0] TX_TAB = 16'he0a0;
  int          hp[4] = '{HALF_20HZ_MS, HALF_10HZ_MS, HALF_5HZ_MS, HALF_2HZ_MS};

  always #5 pclk = ~pclk;

  link_led_ctrl #(.TICK_CYCLES(TK)) link_led_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .strap_led_pol(1'b1), .strap_auto_xover(1'b1),
    .strap_ind_mode(1'b0), .strap_station_addr(5'h0b), .link_up(link_up),
    .link_speed100(spd), .link_full_duplex(fdx), .link_by_autoneg(aneg),
    .activity(act), .local_ability_advert(la), .partner_ability_advert(pa),
    .link_indicator_out(led), .auto_crossover_en(xen), .tx_on_rx_wire_pair(xov));

  led_watch led_watch_inst (
    .pclk(pclk), .presetn(presetn), .led(led), .run_len(run_len), .toggles(toggles));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, x);
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [15:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    wt = 0;
    // Waits as long as the slave asks; only the watchdog ends a hang
    do begin
      @(posedge pclk);
      wt++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [15:0] x);
    apb(a, 1'b0, 16'h0, 4'hf);
    chk(rd, {16'h0, x});
  endtask

  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdchk(ADDR_LED_CTRL, 16'h0400);
    chk(wt, 32'h0000_0001);
    rdchk(ADDR_PHY_CTRL, 16'h800b);
  endtask

  task automatic t_rsvd();
    apb(ADDR_LED_CTRL, 1'b1, 16'hffff, 4'hf);
    rdchk(ADDR_LED_CTRL, 16'h0692);
    apb(ADDR_LED_CTRL, 1'b1, 16'h0000, 4'hf);
    apb(ADDR_LED_CTRL, 1'b1, 16'hffff, 4'h1);
    rdchk(ADDR_LED_CTRL, 16'h0092);
    apb(ADDR_PHY_CTRL, 1'b1, 16'hffff, 4'hf);
    rdchk(ADDR_PHY_CTRL, 16'hc0ab);
    settle();
    chk({xen, xov}, 2'b11);
    apb(ADDR_PHY_CTRL, 1'b1, 16'h0000, 4'hf);
    settle();
    chk({xen, xov}, 2'b00);
    apb(12'h068, 1'b1, 16'hffff, 4'hf);
    chk(er, 1'b1);
    apb(12'h068, 1'b0, 16'h0, 4'hf);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    rdchk(ADDR_PHY_CTRL, 16'h000b);
  endtask

  task automatic t_force();
    link_up <= 1'b1;
    apb(ADDR_LED_CTRL, 1'b1, 16'h0492, 4'hf);
    settle();
    chk(led, 1'b1);
    apb(ADDR_LED_CTRL, 1'b1, 16'h0490, 4'hf);
    settle();
    chk(led, 1'b0);
  endtask

  task automatic t_pol();
    apb(ADDR_PHY_CTRL, 1'b1, 16'h0020, 4'hf);
    apb(ADDR_LED_CTRL, 1'b1, 16'h0480, 4'hf);
    settle();
    chk(led, 1'b1);
    apb(ADDR_LED_CTRL, 1'b1, 16'h0400, 4'hf);
    settle();
    chk(led, 1'b0);
    link_up <= 1'b0;
    settle();
    chk(led, 1'b1);
  endtask

  task automatic t_pause();
    logic lp, la1, rp, ra;
    link_up <= 1'b1;
    spd <= 1'b1;
    fdx <= 1'b1;
    aneg <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      {ra, rp, la1, lp} = i[3:0];
      la <= {4'h0, la1, lp, 10'h0};
      pa <= {4'h0, ra, rp, 10'h0};
      settle();
      apb(ADDR_PHY_CTRL, 1'b0, 16'h0, 4'hf);
      chk(rd[13:11], {RX_TAB[i], TX_TAB[i], 1'b1});
    end
    fdx <= 1'b0;
    settle();
    apb(ADDR_PHY_CTRL, 1'b0, 16'h0, 4'hf);
    chk(rd[13:11], 3'b000);
    fdx <= 1'b1;
    spd <= 1'b0;
    settle();
    apb(ADDR_PHY_CTRL, 1'b0, 16'h0, 4'hf);
    chk(rd[13:11], 3'b110);
  endtask

  task automatic wait_tog(input int n);
    int k;
    logic [7:0] t0;
    t0 = toggles;
    for (k = 0; k < 20000 && 8'(toggles - t0) < n; k++) @(posedge pclk);
    chk(k < 20000, 1'b1);
  endtask

  task automatic t_blink();
    apb(ADDR_PHY_CTRL, 1'b1, 16'h0000, 4'hf);
    act <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      apb(ADDR_LED_CTRL, 1'b1, {5'h0, r[1:0], 9'h080}, 4'hf);
      wait_tog(3);
      chk(run_len, hp[r] * TK);
    end
    apb(ADDR_PHY_CTRL, 1'b1, 16'h0080, 4'hf);
    settle();
    chk(led, 1'b0);
    act <= 1'b0;
    settle();
    chk(led, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("Checks %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_reset();
    t_rsvd();
    t_force();
    t_pol();
    t_pause();
    t_blink();
    summarize();
  end

  // Run needs about 25200 cycles; reaching 60000 means a hang
  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    summarize();
  end
endmodule
